// [hw/static_bank_bus_cycle_engine.sv]
// The implementer's own choice: the APB slave port.
`default_nettype none
module static_bank_bus_cycle_engine
	import static_bank_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System bus request
	input wire logic req_valid,
	input wire mem_req_type req,
	output logic req_ready,
	// System bus answer
	output logic rsp_valid,
	output logic rsp_last,
	output logic [31:0] rsp_rdata,
	// Memory pins
	output logic [25:0] mem_addr,
	output logic [31:0] mem_data_out,
	output logic mem_data_oe,
	input wire logic [31:0] mem_data_in,
	output logic [3:0] bank_select_n,
	output logic [3:0] flash_chip_enable_n,
	output logic read_n,
	output logic write_n,
	output logic [3:0] byte_we_n,
	input wire logic wait_n,
	// Boot strap
	input wire logic boot_from_nand
);
	bank_cfg_type [3:0] bank_cfg;
	logic [3:0] flash_ce_force;
	logic [3:0] flash_bank_enable;
	cycle_state_type state_r;
	cycle_state_type state_nxt;
	mem_req_type cur_r;
	bank_cfg_type cfg_r;
	bank_cfg_type new_cfg;
	logic [4:0] cnt_r;
	logic [5:0] beats_r;
	logic first_r;
	logic [25:0] mem_addr_r;
	logic [31:0] wdata_r;
	logic oe_r;
	logic [31:0] rdata_r;
	logic rsp_valid_r;
	logic rsp_last_r;
	logic [5:0] beat_len_r;
	logic is_burst;
	logic byte_ctl;
	logic [3:0] beat_waits;
	logic beat_end;
	logic burst_more;
	logic fin;
	logic chain;
	logic take;
	logic cs_on;
	logic strobe_on;
	logic [25:0] step;

	bank_config_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.boot_from_nand(boot_from_nand),
		.bank_cfg(bank_cfg),
		.flash_ce_force(flash_ce_force),
		.flash_bank_enable(flash_bank_enable)
	);

	// Strobe length: waits plus inherent cycles (read 1, write 2)
	function automatic logic [4:0] strobe_load(bank_cfg_type c, logic wr);
		logic [3:0] w;
		w = (c.memory_type_select == MEM_BURST_ROM) ? c.access
			: c.pitch;
		if (wr)
			return {1'b0, w} + 5'h01;
		return {1'b0, c.access};
	endfunction

	assign new_cfg = bank_cfg[req.bank];
	assign is_burst = cfg_r.memory_type_select == MEM_BURST_ROM;
	assign byte_ctl = cfg_r.byte_control_mode && !is_burst;
	assign cs_on = state_r != ST_IDLE;
	assign strobe_on = state_r == ST_STROBE;

	// Later burst beats are paced by pitch, the first by access
	assign beat_waits = (!cur_r.write && !first_r) ? cfg_r.pitch
		: (cur_r.write && !is_burst) ? cfg_r.pitch : cfg_r.access;
	// Wait pin only honoured when waits are programmed
	assign beat_end = strobe_on && cnt_r == 5'h00
		&& !(beat_waits != 4'h0 && !wait_n);
	assign burst_more = is_burst && !cur_r.write
		&& beats_r != 6'h00;
	assign fin = beat_end && !burst_more;
	// Chaining needs zero hold; the strobe stays up if the next setup is zero
	assign chain = fin && cfg_r.hold == 2'h0 && req_valid;
	assign req_ready = state_r == ST_IDLE || chain;
	assign take = req_valid && req_ready;

	// Reserved width code steps like 8-bit
	always_comb
	begin
		unique case (cfg_r.bus_width_field)
			WIDTH_16: step = 26'd2;
			WIDTH_32: step = 26'd4;
			default: step = 26'd1;
		endcase
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:
				if (take)
					state_nxt = (new_cfg.setup != 2'h0) ? ST_SETUP : ST_STROBE;
			ST_SETUP:
				if (cnt_r == 5'h00)
					state_nxt = ST_STROBE;
			ST_STROBE:
				if (take)
					state_nxt = (new_cfg.setup != 2'h0) ? ST_SETUP : ST_STROBE;
				else if (fin)
					state_nxt = (cfg_r.hold != 2'h0) ? ST_HOLD : ST_IDLE;
			ST_HOLD:
				if (cnt_r == 5'h00)
					state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Request and settings are frozen for the whole access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_r <= '0;
			cfg_r <= '0;
		end
		else if (take)
		begin
			cur_r <= req;
			cfg_r <= new_cfg;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_r <= 5'h00;
		else if (take)
		begin
			if (new_cfg.setup != 2'h0)
				cnt_r <= {3'h0, new_cfg.setup} - 5'h01;
			else
				cnt_r <= strobe_load(new_cfg, req.write);
		end
		else
		begin
			unique case (state_r)
				ST_SETUP:
					if (cnt_r == 5'h00)
						cnt_r <= strobe_load(cfg_r, cur_r.write);
					else
						cnt_r <= cnt_r - 5'h01;
				ST_STROBE:
					if (beat_end && burst_more)
						cnt_r <= {1'b0, cfg_r.pitch};
					else if (beat_end)
						cnt_r <= {3'h0, cfg_r.hold} - 5'h01;
					else if (cnt_r != 5'h00)
						cnt_r <= cnt_r - 5'h01;
				ST_HOLD:
					cnt_r <= cnt_r - 5'h01;
				ST_IDLE:
					cnt_r <= 5'h00;
			endcase
		end
	end

	// Beats left in a burst read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			beats_r <= 6'h00;
			first_r <= 1'b0;
		end
		else if (take)
		begin
			beats_r <= (BURST_BASE_BEATS << new_cfg.burst_length_field)
				- 6'h01;
			first_r <= 1'b1;
		end
		else if (beat_end)
		begin
			beats_r <= beats_r - 6'h01;
			first_r <= 1'b0;
		end
	end

	// Address and write data stay put through hold
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_addr_r <= 26'h000_0000;
			wdata_r <= 32'h0000_0000;
			oe_r <= 1'b0;
		end
		else if (take)
		begin
			mem_addr_r <= req.addr;
			wdata_r <= req.wdata;
			oe_r <= req.write;
		end
		else
		begin
			if (beat_end && burst_more)
				mem_addr_r <= mem_addr_r + step;
			if (state_nxt == ST_IDLE)
				oe_r <= 1'b0;
		end
	end

	// Data taken at the last strobe cycle of each beat
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_r <= 32'h0000_0000;
			rsp_valid_r <= 1'b0;
			rsp_last_r <= 1'b0;
		end
		else
		begin
			rsp_valid_r <= beat_end;
			rsp_last_r <= fin;
			if (beat_end && !cur_r.write)
				rdata_r <= mem_data_in;
		end
	end

	// Strobe cycles in the current beat, for checking only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			beat_len_r <= 6'h00;
		else if (state_nxt == ST_STROBE
			&& (!strobe_on || beat_end || take))
			beat_len_r <= 6'h01;
		else if (strobe_on && beat_len_r != 6'h3f)
			beat_len_r <= beat_len_r + 6'h01;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_pin
			// NAND banks use the flash enable in place of the select
			assign bank_select_n[g] = !(cs_on && cur_r.bank == 2'(g)
				&& !flash_bank_enable[g]);
			assign flash_chip_enable_n[g] = !(flash_ce_force[g]
				|| (cs_on && cur_r.bank == 2'(g)
				&& flash_bank_enable[g]));
		end
	endgenerate

	// All normal memory kinds share one strobe scheme
	assign read_n = !(strobe_on && !cur_r.write);
	assign write_n = !(strobe_on && cur_r.write);
	assign byte_we_n = byte_ctl ? ~(cur_r.be & {4{strobe_on}})
		: ~(cur_r.be & {4{strobe_on && cur_r.write}});
	assign mem_addr = mem_addr_r;
	assign mem_data_out = wdata_r;
	assign mem_data_oe = oe_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_last = rsp_last_r;
	assign rsp_rdata = rdata_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_take_fast_read;
		take && !req.write && new_cfg.setup == 2'h0
			&& new_cfg.access == 4'h0
			&& new_cfg.memory_type_select == MEM_NORMAL;
	endsequence

	sequence s_one_beat_read;
		!read_n ##1 (rsp_valid && rsp_last);
	endsequence

	a_select_with_addr: assert property (
		take |=> (cs_on && mem_addr == $past(req.addr)))
		else $error("select or address missing after take");

	a_setup_no_strobe: assert property (
		state_r == ST_SETUP |-> (read_n && write_n))
		else $error("strobe during setup");

	a_setup_to_strobe: assert property (
		(state_r == ST_SETUP && cnt_r == 5'h00 && !take)
			|=> strobe_on)
		else $error("strobe late after setup");

	a_read_access_len: assert property (
		(beat_end && !cur_r.write && first_r)
			|-> beat_len_r >= {2'h0, cfg_r.access} + 6'h01)
		else $error("read strobe shorter than access waits");

	a_write_pitch_len: assert property (
		(beat_end && cur_r.write && !is_burst)
			|-> beat_len_r >= {2'h0, cfg_r.pitch} + 6'h02)
		else $error("write strobe shorter than pitch");

	a_wait_extends: assert property (
		(strobe_on && cnt_r == 5'h00 && beat_waits != 4'h0 && !wait_n)
			|=> strobe_on && $stable(mem_addr))
		else $error("wait input ignored");

	a_hold_keeps_cs: assert property (
		(fin && cfg_r.hold != 2'h0)
			|=> (cs_on && read_n && write_n && $stable(mem_addr)))
		else $error("select dropped in hold");

	a_read_one_cycle: assert property (
		s_take_fast_read |=> s_one_beat_read)
		else $error("zero wait read not one cycle");

	a_burst_strobe_kept: assert property (
		(beat_end && burst_more) |=> (!read_n && cs_on))
		else $error("strobe dropped inside burst");

	a_force_enable: assert property (
		(flash_ce_force & flash_chip_enable_n) == 4'h0)
		else $error("forced flash enable not asserted");

	a_single_bank: assert property (
		$onehot0(~bank_select_n))
		else $error("two bank selects active");
endmodule // static_bank_bus_cycle_engine
`default_nettype wire

// [hw/static_bank_pkg.sv]
`default_nettype none
package static_bank_pkg;
	// Register map
	localparam logic [31:0] FLASH_CTRL_ADDR = 32'h1301_0050;
	localparam logic [31:0] BANK_CTRL_BASE = 32'h1301_0010;
	localparam logic [31:0] FLASH_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] BANK_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] BANK_CTRL_MASK = 32'h000f_ffcf;
	localparam int FLASH_CTRL_BITS = 8;
	localparam int BOOT_BANK = 0;
	// Bank control fields
	localparam int MEM_TYPE_BIT = 0;
	localparam int BURST_LEN_LSB = 1;
	localparam int BYTE_CTL_BIT = 3;
	localparam int BUS_WIDTH_LSB = 6;
	localparam int SETUP_LSB = 8;
	localparam int HOLD_LSB = 10;
	localparam int ACCESS_LSB = 12;
	localparam int PITCH_LSB = 16;
	// Bus width codes
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;
	localparam logic [5:0] BURST_BASE_BEATS = 6'h04;

	typedef enum logic {
		MEM_NORMAL = 1'b0,
		MEM_BURST_ROM = 1'b1
	} mem_kind_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_STROBE = 2'b11,
		ST_HOLD = 2'b10
	} cycle_state_type;

	typedef struct packed {
		logic [3:0] pitch;
		logic [3:0] access;
		logic [1:0] hold;
		logic [1:0] setup;
		logic [1:0] bus_width_field;
		logic byte_control_mode;
		logic [1:0] burst_length_field;
		mem_kind_type memory_type_select;
	} bank_cfg_type;

	typedef struct packed {
		logic [1:0] bank;
		logic write;
		logic [25:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} mem_req_type;
endpackage
`default_nettype wire

// [hw/bank_config_regs.sv]
`default_nettype none
module bank_config_regs
	import static_bank_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Boot strap
	input wire logic boot_from_nand,
	// Configuration out
	output bank_cfg_type [3:0] bank_cfg,
	output logic [3:0] flash_ce_force,
	output logic [3:0] flash_bank_enable
);
	logic [31:0] bank_ctrl_r [4];
	logic [FLASH_CTRL_BITS-1:0] flash_ctrl_r;
	logic [31:0] prdata_r;
	logic strap_done_r;
	logic bank_hit;
	logic flash_hit;
	logic wr_en;

	assign bank_hit = paddr[31:4] == BANK_CTRL_BASE[31:4]
		&& paddr[1:0] == 2'h0;
	assign flash_hit = paddr == FLASH_CTRL_ADDR;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !bank_hit && !flash_hit;
	assign prdata = prdata_r;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_bank
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					bank_ctrl_r[g] <= BANK_CTRL_RESET;
				else if (wr_en && bank_hit && paddr[3:2] == 2'(g))
					bank_ctrl_r[g] <= pwdata & BANK_CTRL_MASK;
			end
			// Fields picked by position, skipping the reserved pair
			assign bank_cfg[g] = '{
				pitch: bank_ctrl_r[g][PITCH_LSB +: 4],
				access: bank_ctrl_r[g][ACCESS_LSB +: 4],
				hold: bank_ctrl_r[g][HOLD_LSB +: 2],
				setup: bank_ctrl_r[g][SETUP_LSB +: 2],
				bus_width_field: bank_ctrl_r[g][BUS_WIDTH_LSB +: 2],
				byte_control_mode: bank_ctrl_r[g][BYTE_CTL_BIT],
				burst_length_field: bank_ctrl_r[g][BURST_LEN_LSB +: 2],
				memory_type_select:
					mem_kind_type'(bank_ctrl_r[g][MEM_TYPE_BIT])
			};
			assign flash_bank_enable[g] = flash_ctrl_r[2*g];
			assign flash_ce_force[g] = flash_ctrl_r[2*g+1];
		end
	endgenerate

	// Strap is caught on the first edge after release, never by reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_ctrl_r <= FLASH_CTRL_RESET[FLASH_CTRL_BITS-1:0];
			strap_done_r <= 1'b0;
		end
		else
		begin
			strap_done_r <= 1'b1;
			if (wr_en && flash_hit)
				flash_ctrl_r <= pwdata[FLASH_CTRL_BITS-1:0];
			else if (!strap_done_r)
				flash_ctrl_r[2*BOOT_BANK] <= boot_from_nand;
		end
	end

	// Read data prepared in the setup phase, so no wait state is needed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			if (bank_hit)
				prdata_r <= bank_ctrl_r[paddr[3:2]];
			else if (flash_hit)
				prdata_r <= {24'h00_0000, flash_ctrl_r};
			else
				prdata_r <= 32'h0000_0000;
		end
	end
endmodule // bank_config_regs
`default_nettype wire

// [tb/sram_chip_model.sv]
`default_nettype none
module sram_chip_model (
	// Bus side
	input wire logic pclk,
	input wire logic [25:0] mem_addr,
	input wire logic [31:0] mem_data_out,
	input wire logic [3:0] bank_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic [3:0] byte_we_n,
	input wire logic [3:0] wait_len,
	// Chip answer
	output logic [31:0] mem_data_in,
	output logic wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	logic [31:0] last_r;
	logic [3:0] strobe_cnt_r;
	logic sel;
	logic strobe;
	assign sel = ~&bank_select_n;
	assign strobe = sel && !(read_n && write_n);
	// Released bus flips every cycle, so stale data never matches
	assign mem_data_in = (sel && !read_n) ? mem[mem_addr[5:2]] : ~last_r;
	// Hold off the first wait_len strobe cycles
	assign wait_n = !(strobe && strobe_cnt_r < wait_len);
	always_ff @(posedge pclk)
	begin
		strobe_cnt_r <= strobe ? strobe_cnt_r + 4'h1 : 4'h0;
		last_r <= mem_data_in;
		for (int i = 0; i < 4; i++)
			if (sel && !write_n && !byte_we_n[i])
				mem[mem_addr[5:2]][8*i +: 8] <= mem_data_out[8*i +: 8];
	end
endmodule // sram_chip_model
`default_nettype wire

// [tb/static_bank_bus_cycle_engine_tb_top.sv]
`default_nettype none
module static_bank_bus_cycle_engine_tb_top
	import static_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rdata, rsp_rdata;
	logic req_valid, req_ready, rsp_valid, rsp_last, boot_from_nand;
	mem_req_type req;
	logic [31:0] mem_data_out, mem_data_in;
	logic [25:0] mem_addr;
	logic mem_data_oe, read_n, write_n, wait_n;
	logic [3:0] bank_select_n, flash_chip_enable_n, byte_we_n, wait_len;
	logic [31:0] rd_q [32];
	int mismatches, check_count, cycles, beats, slen, su, ho, bsel, oe_err;
	localparam logic [31:0] BANK1 = BANK_CTRL_BASE + 32'h4;

	static_bank_bus_cycle_engine dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
		.rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
		.mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
		.mem_data_in(mem_data_in), .bank_select_n(bank_select_n),
		.flash_chip_enable_n(flash_chip_enable_n), .read_n(read_n),
		.write_n(write_n), .byte_we_n(byte_we_n), .wait_n(wait_n),
		.boot_from_nand(boot_from_nand));
	sram_chip_model chip (.pclk(pclk), .mem_addr(mem_addr),
		.mem_data_out(mem_data_out), .bank_select_n(bank_select_n),
		.read_n(read_n), .write_n(write_n), .byte_we_n(byte_we_n),
		.wait_len(wait_len), .mem_data_in(mem_data_in), .wait_n(wait_n));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] cfg(input logic mtype, input logic bctl,
		input int s, input int h, input int a, input int p);
		// 32-bit width, four-beat bursts
		return {12'h0, p[3:0], a[3:0], h[1:0], s[1:0], 2'h2, 2'h0, bctl,
			2'h0, mtype};
	endfunction

	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic acc(input logic [1:0] b, input logic w,
		input logic [25:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		beats = 0;
		slen = 0;
		su = 0;
		ho = 0;
		bsel = 0;
		req <= '{bank: b, write: w, addr: a, wdata: d, be: be};
		req_valid <= 1'b1;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 100);
		@(posedge pclk);
		req_valid <= 1'b0;
		// Watch one cycle per falling edge, settled values only
		while (n < 400 && !(done && bank_select_n[b]))
		begin
			@(negedge pclk);
			n++;
			if (!bank_select_n[b] && !(read_n && write_n))
				slen++;
			else if (!bank_select_n[b] && slen == 0)
				su++;
			else if (!bank_select_n[b])
				ho++;
			if (!w && byte_we_n !== 4'hf)
				bsel = 1;
			// Write data driven exactly while the select is low
			if (mem_data_oe !== (w && !bank_select_n[b]))
				oe_err++;
			if (rsp_valid === 1'b1)
			begin
				rd_q[beats] = rsp_rdata;
				beats++;
				done = rsp_last;
			end
		end
		@(posedge pclk);
	endtask

	task automatic t_regs();
		apb(1'b0, FLASH_CTRL_ADDR, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b0, BANK1, 32'h0);
		chk(rdata, BANK_CTRL_RESET);
		apb(1'b1, BANK1, 32'hffff_ffff);
		apb(1'b0, BANK1, 32'h0);
		chk(rdata, BANK_CTRL_MASK);
		apb(1'b0, 32'h1301_0060, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask

	task automatic t_force();
		apb(1'b1, FLASH_CTRL_ADDR, 32'hffff_ffaa);
		apb(1'b0, FLASH_CTRL_ADDR, 32'h0);
		chk(rdata, 32'haa);
		chk(flash_chip_enable_n, 4'h0);
		apb(1'b1, FLASH_CTRL_ADDR, 32'h2);
		chk(flash_chip_enable_n, 4'he);
		apb(1'b1, FLASH_CTRL_ADDR, 32'h0);
		chk(flash_chip_enable_n, 4'hf);
	endtask

	task automatic t_normal(input int s, input int h, input int a, input int p);
		apb(1'b1, BANK1, cfg(1'b0, 1'b0, s, h, a, p));
		acc(2'h1, 1'b1, 26'h8, 32'ha5c3_1e7f, 4'hf);
		chk(slen, p + 2);
		chk(su, s);
		chk(ho, h);
		acc(2'h1, 1'b0, 26'h8, 32'h0, 4'hf);
		chk(slen, a + 1);
		chk(rd_q[0], 32'ha5c3_1e7f);
		chk(su + ho, s + h);
		chk(oe_err, 0);
	endtask

	task automatic t_wait();
		apb(1'b1, BANK1, cfg(1'b0, 1'b0, 1, 1, 1, 1));
		wait_len <= 4'h4;
		acc(2'h1, 1'b0, 26'h8, 32'h0, 4'hf);
		chk(slen, 5);
		apb(1'b1, BANK1, cfg(1'b0, 1'b0, 1, 1, 0, 0));
		acc(2'h1, 1'b0, 26'h8, 32'h0, 4'hf);
		chk(slen, 1);
		wait_len <= 4'h0;
	endtask

	task automatic t_bytectl();
		apb(1'b1, BANK1, cfg(1'b0, 1'b1, 1, 1, 1, 1));
		acc(2'h1, 1'b1, 26'hc, 32'h1234_5678, 4'hf);
		acc(2'h1, 1'b0, 26'hc, 32'h0, 4'h3);
		chk(bsel, 1);
		chk(rd_q[0], 32'h1234_5678);
	endtask

	task automatic t_burst();
		apb(1'b1, BANK1, cfg(1'b1, 1'b1, 1, 1, 2, 1));
		for (int i = 0; i < 4; i++)
		begin
			acc(2'h1, 1'b1, 26'h10 + 26'(4 * i), 32'hc0de_0000 + i, 4'hf);
			chk(slen, 4);
		end
		acc(2'h1, 1'b0, 26'h10, 32'h0, 4'hf);
		chk(bsel, 0);
		chk(beats, 4);
		for (int i = 0; i < 4; i++)
			chk(rd_q[i], 32'hc0de_0000 + i);
		// 16-bit width, eight beats: each word read twice
		apb(1'b1, BANK1, cfg(1'b1, 1'b0, 1, 1, 2, 1) ^ 32'hc2);
		acc(2'h1, 1'b0, 26'h10, 32'h0, 4'hf);
		chk(beats, 8);
		for (int i = 0; i < 8; i++)
			chk(rd_q[i], 32'hc0de_0000 + (i >> 1));
	endtask

	task automatic t_chain();
		int gaps;
		gaps = 0;
		apb(1'b1, BANK1, cfg(1'b0, 1'b0, 0, 0, 0, 0));
		req <= '{bank: 2'h1, write: 1'b0, addr: 26'h8, wdata: 32'h0,
			be: 4'hf};
		req_valid <= 1'b1;
		@(posedge pclk);
		req <= '{bank: 2'h1, write: 1'b0, addr: 26'hc, wdata: 32'h0,
			be: 4'hf};
		@(negedge pclk);
		if (read_n !== 1'b0 || req_ready !== 1'b1)
			gaps++;
		@(posedge pclk);
		req_valid <= 1'b0;
		@(negedge pclk);
		if (read_n !== 1'b0 || rsp_valid !== 1'b1)
			gaps++;
		chk(rsp_rdata, 32'ha5c3_1e7f);
		@(negedge pclk);
		chk({30'h0, rsp_valid, rsp_last}, 32'h3);
		chk(rsp_rdata, 32'h1234_5678);
		chk(gaps, 0);
		@(posedge pclk);
	endtask

	task automatic t_boot();
		boot_from_nand <= 1'b1;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, FLASH_CTRL_ADDR, 32'h0);
		chk(rdata, 32'h1);
	endtask

	initial
	begin
		cycles = 0;
		mismatches = 0;
		check_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		req_valid = 1'b0;
		req = '0;
		wait_len = 4'h0;
		boot_from_nand = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_regs();
		t_force();
		t_normal(1, 2, 2, 1);
		t_normal(0, 0, 0, 0);
		t_wait();
		t_bytectl();
		t_burst();
		t_chain();
		t_boot();
		stop_test();
	end
endmodule // static_bank_bus_cycle_engine_tb_top
`default_nettype wire
